// ===== design/brkb_defs.svh
// Constants of the channel B break data and bus cycle match unit.
// Assumes a single 25 MHz system clock and one register port per unit.
`ifndef BRKB_DEFS_SVH
`define BRKB_DEFS_SVH

// Register indices on the register port
`define BRKB_IDX_DATA 2'h0
`define BRKB_IDX_MASK 2'h1
`define BRKB_IDX_CYC 2'h2
`define BRKB_IDX_CTRL 2'h3

// Reset values
`define BRKB_RST_WORD 32'h0000_0000
`define BRKB_RST_CYC 8'h00
`define BRKB_RST_FLAGS 2'h0

// Bus cycle select register fields
`define BRKB_CYC_W 8
`define BRKB_CYC_PAD 24'h00_0000
`define BRKB_BUS_HI 7
`define BRKB_BUS_LO 6
`define BRKB_ACC_HI 5
`define BRKB_ACC_LO 4
`define BRKB_DIR_HI 3
`define BRKB_DIR_LO 2
`define BRKB_SZ_HI 1
`define BRKB_SZ_LO 0

// Control and flag register fields
`define BRKB_FLAG_LOCAL 0
`define BRKB_FLAG_INTERNAL 1
`define BRKB_DATA_EN 2
`define BRKB_CTRL_PAD 29'h0000_0000

// Selector encodings
`define BRKB_SEL_OFF 2'h0
`define BRKB_BUS_LOCAL_A 2'h1
`define BRKB_BUS_INTERNAL 2'h2
`define BRKB_BUS_LOCAL_B 2'h3
`define BRKB_SZ_BYTE 2'h1
`define BRKB_SZ_WORD 2'h2
`define BRKB_SZ_LONG 2'h3

// Byte lanes
`define BRKB_LANE0_HI 7
`define BRKB_LANE1_HI 15
`define BRKB_LANE1_LO 8
`define BRKB_HALF_HI 15

`endif

// ===== design/brkb_pkg.sv
// Types shared by both ends of the channel B break match unit.
// Assumes brkb_defs.svh for the numeric constants.
package brkb_pkg;

   // One observed bus cycle on the local or the internal bus
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic [1:0] size;
      logic [31:0] data;
   } brkb_cycle_s;

   // Programming end sequencer states
   typedef enum logic [0:0] {
      BRKB_HS_IDLE,
      BRKB_HS_WAIT
   } brkb_hstate_e;

endpackage

// ===== design/brkb_if.sv
// Register port between the programming end and the match unit.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ns
interface brkb_if;
   logic req;
   logic we;
   logic [1:0] idx;
   logic [31:0] wdata;
   logic ack;
   logic [31:0] rdata;

   modport dev (
      input req,
      input we,
      input idx,
      input wdata,
      output ack,
      output rdata
   );

   modport host (
      output req,
      output we,
      output idx,
      output wdata,
      input ack,
      input rdata
   );
endinterface

// ===== design/brkb_cmp.sv
// Qualifier and masked data compare for one observed bus.
// Assumes the cycle inputs are already on the system clock; purely combinational.
`timescale 1ns/1ns
`include "brkb_defs.svh"
module brkb_cmp #(
   parameter int DW = 32
) (
   input wire logic [1:0] acc_sel,
   input wire logic [1:0] dir_sel,
   input wire logic [1:0] size_sel,
   input wire logic data_en,
   input wire logic [DW-1:0] ref_data,
   input wire logic [DW-1:0] ref_mask,
   input wire brkb_pkg::brkb_cycle_s cyc,
   output logic hit
);
   logic [DW-1:0] diff;
   logic acc_ok;
   logic dir_ok;
   logic size_ok;
   logic data_ok;
   logic lane_ok;

   // Mask bit one drops that bit from the compare
   assign diff = (cyc.data ^ ref_data) & ~ref_mask;

   // Fetch / data access qualifier, off means not compared
   assign acc_ok = (acc_sel == `BRKB_SEL_OFF) ||
                   (acc_sel[0] && cyc.fetch) || (acc_sel[1] && !cyc.fetch);

   // Read / write qualifier
   assign dir_ok = (dir_sel == `BRKB_SEL_OFF) ||
                   (dir_sel[0] && !cyc.write) || (dir_sel[1] && cyc.write);

   // Operand size qualifier
   assign size_ok = (size_sel == `BRKB_SEL_OFF) || (size_sel == cyc.size);

   // A byte may ride either low lane, hence both lanes hold the same byte
   always_comb begin
      unique case (size_sel)
         `BRKB_SZ_BYTE: lane_ok = !(|diff[`BRKB_LANE0_HI:0]) ||
            !(|diff[`BRKB_LANE1_HI:`BRKB_LANE1_LO]);
         `BRKB_SZ_WORD: lane_ok = !(|diff[`BRKB_HALF_HI:0]);
         default: lane_ok = !(|diff);
      endcase
   end

   assign data_ok = !data_en || lane_ok;

   // Every enabled qualifier must hold in the same cycle
   assign hit = cyc.valid && acc_ok && dir_ok && size_ok && data_ok;
endmodule // brkb_cmp

// ===== design/brkb_dev.sv
// Channel B break data and bus cycle match unit, documented device end.
// Assumes the local and internal bus cycle views come from logic on clk_sys
// and that the programming end issues one register request at a time.
`timescale 1ns/1ns
`include "brkb_defs.svh"
module brkb_dev #(
   parameter int DW = 32,
   parameter int NBUS = 2
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   brkb_if.dev rb,
   input wire brkb_pkg::brkb_cycle_s local_cycle,
   input wire brkb_pkg::brkb_cycle_s internal_cycle,
   output logic local_hit_q,
   output logic internal_hit_q,
   output logic local_flag_q,
   output logic internal_flag_q
);
   // Stored settings
   logic [DW-1:0] chan_b_break_data_q;
   logic [DW-1:0] chan_b_break_data_mask_q;
   logic [`BRKB_CYC_W-1:0] chan_b_bus_cycle_select_q;
   logic data_en_q;
   logic [NBUS-1:0] flag_q;
   logic [NBUS-1:0] flag_d;
   logic [NBUS-1:0] hit_q;
   logic ack_q;
   logic [DW-1:0] rdata_q;

   // Decoded fields and per-bus results
   logic [1:0] bus_sel;
   logic [1:0] acc_sel;
   logic [1:0] dir_sel;
   logic [1:0] size_sel;
   logic [NBUS-1:0] bus_en;
   logic [NBUS-1:0] raw_hit;
   logic [NBUS-1:0] hit;
   brkb_pkg::brkb_cycle_s cyc_in [NBUS];

   // Write strobes
   logic wr_data;
   logic wr_mask;
   logic wr_cyc;
   logic wr_ctrl;

   // Register write decode, used by every register process
   function automatic logic wr_hit(input logic req, input logic we,
                                   input logic [1:0] idx,
                                   input logic [1:0] want);
      wr_hit = req && we && (idx == want);
   endfunction

   assign wr_data = wr_hit(rb.req, rb.we, rb.idx, `BRKB_IDX_DATA);
   assign wr_mask = wr_hit(rb.req, rb.we, rb.idx, `BRKB_IDX_MASK);
   assign wr_cyc = wr_hit(rb.req, rb.we, rb.idx, `BRKB_IDX_CYC);
   assign wr_ctrl = wr_hit(rb.req, rb.we, rb.idx, `BRKB_IDX_CTRL);

   // Break data comparand
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan_b_break_data_q <= `BRKB_RST_WORD;
      end else if (wr_data) begin
         chan_b_break_data_q <= rb.wdata;
      end
   end

   // Break data mask; lane duplication for byte size is left to software
   // A mask set in one byte lane only would let a byte match slip through
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan_b_break_data_mask_q <= `BRKB_RST_WORD;
      end else if (wr_mask) begin
         chan_b_break_data_mask_q <= rb.wdata;
      end
   end

   // Bus cycle select; the reserved upper three bytes are never stored
   // Writes to the reserved bytes are dropped, reads return zero there
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan_b_bus_cycle_select_q <= `BRKB_RST_CYC;
      end else if (wr_cyc) begin
         chan_b_bus_cycle_select_q <= rb.wdata[`BRKB_CYC_W-1:0];
      end
   end

   // Data include enable, taken into the compare only when set
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_en_q <= 1'b0;
      end else if (wr_ctrl) begin
         data_en_q <= rb.wdata[`BRKB_DATA_EN];
      end
   end

   // Field split of the bus cycle select register
   assign bus_sel = chan_b_bus_cycle_select_q[`BRKB_BUS_HI:`BRKB_BUS_LO];
   assign acc_sel = chan_b_bus_cycle_select_q[`BRKB_ACC_HI:`BRKB_ACC_LO];
   assign dir_sel = chan_b_bus_cycle_select_q[`BRKB_DIR_HI:`BRKB_DIR_LO];
   assign size_sel = chan_b_bus_cycle_select_q[`BRKB_SZ_HI:`BRKB_SZ_LO];

   // Both odd codes pick the local bus; off picks neither
   assign bus_en[`BRKB_FLAG_LOCAL] = (bus_sel == `BRKB_BUS_LOCAL_A) ||
                                     (bus_sel == `BRKB_BUS_LOCAL_B);
   assign bus_en[`BRKB_FLAG_INTERNAL] = (bus_sel == `BRKB_BUS_INTERNAL);

   assign cyc_in[`BRKB_FLAG_LOCAL] = local_cycle;
   assign cyc_in[`BRKB_FLAG_INTERNAL] = internal_cycle;

   // One comparator per bus; the selector gates which one may match
   // Both comparators run every cycle; gating after them keeps the
   // qualifier logic identical for the two buses
   for (genvar g = 0; g < NBUS; g++) begin : g_bus
      brkb_cmp #(
         .DW(DW)
      ) u_cmp (
         .acc_sel(acc_sel),
         .dir_sel(dir_sel),
         .size_sel(size_sel),
         .data_en(data_en_q),
         .ref_data(chan_b_break_data_q),
         .ref_mask(chan_b_break_data_mask_q),
         .cyc(cyc_in[g]),
         .hit(raw_hit[g])
      );
      assign hit[g] = raw_hit[g] && bus_en[g];
   end

   // Sticky flags: a hit in the clearing cycle wins over the clear,
   // so a match that lands on a clear is never lost; software must
   // clear again once it has read the flag
   always_comb begin
      flag_d = flag_q;
      for (int i = 0; i < NBUS; i++) begin
         if (hit[i]) begin
            flag_d[i] = 1'b1;
         end else if (wr_ctrl && !rb.wdata[i]) begin
            flag_d[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= `BRKB_RST_FLAGS;
      end else begin
         flag_q <= flag_d;
      end
   end

   // Registered one-cycle match pulses, one cycle after the bus cycle
   // Registering costs a cycle of latency but keeps the outputs glitch free
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hit_q <= `BRKB_RST_FLAGS;
      end else begin
         hit_q <= hit;
      end
   end

   // Acknowledge every request one cycle later, reads and writes alike;
   // nothing is ever refused, so the programming end needs no wait
   // states beyond this single cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= rb.req;
      end
   end

   // Read data shows the value held before a write in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `BRKB_RST_WORD;
      end else if (rb.req && !rb.we) begin
         unique case (rb.idx)
            `BRKB_IDX_DATA: rdata_q <= chan_b_break_data_q;
            `BRKB_IDX_MASK: rdata_q <= chan_b_break_data_mask_q;
            `BRKB_IDX_CYC: rdata_q <= {`BRKB_CYC_PAD,
                                       chan_b_bus_cycle_select_q};
            `BRKB_IDX_CTRL: rdata_q <= {`BRKB_CTRL_PAD, data_en_q, flag_q};
         endcase
      end
   end

   // Port drive, all straight from flip-flops
   assign rb.ack = ack_q;
   assign rb.rdata = rdata_q;
   assign local_hit_q = hit_q[`BRKB_FLAG_LOCAL];
   assign internal_hit_q = hit_q[`BRKB_FLAG_INTERNAL];
   assign local_flag_q = flag_q[`BRKB_FLAG_LOCAL];
   assign internal_flag_q = flag_q[`BRKB_FLAG_INTERNAL];
endmodule // brkb_dev

// ===== design/brkb_host.sv
// Programming end of the channel B break match unit.
// Assumes the match unit answers each request within a few cycles.
`timescale 1ns/1ns
`include "brkb_defs.svh"
module brkb_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   brkb_if.host rb,
   input wire logic cmd_valid,
   input wire logic cmd_we,
   input wire logic [1:0] cmd_idx,
   input wire logic [31:0] cmd_wdata,
   output logic cmd_busy_q,
   output logic cmd_done_q,
   output logic cmd_err_q,
   output logic [31:0] cmd_rdata_q
);
   brkb_pkg::brkb_hstate_e state_q;
   logic req_q;
   logic we_q;
   logic [1:0] idx_q;
   logic [31:0] wdata_q;
   logic [31:0] wdata_d;
   logic err_d;
   logic [1:0] size_q;
   logic take;

   assign take = cmd_valid && (state_q == brkb_pkg::BRKB_HS_IDLE);

   // Shape the write for the size shadow of the moment; settings stored before a later size write are not reshaped
   always_comb begin
      wdata_d = cmd_wdata;
      err_d = 1'b0;
      unique case (cmd_idx)
         `BRKB_IDX_DATA, `BRKB_IDX_MASK: begin
            if (size_q == `BRKB_SZ_BYTE) begin
               wdata_d[`BRKB_LANE1_HI:`BRKB_LANE1_LO] =
                  cmd_wdata[`BRKB_LANE0_HI:0];
            end
         end
         `BRKB_IDX_CYC: begin
            wdata_d = {`BRKB_CYC_PAD, cmd_wdata[`BRKB_CYC_W-1:0]};
         end
         `BRKB_IDX_CTRL: begin
            if (cmd_wdata[`BRKB_DATA_EN] && size_q == `BRKB_SEL_OFF) begin
               wdata_d[`BRKB_DATA_EN] = 1'b0;
               err_d = 1'b1;
            end
         end
      endcase
   end

   // Shadow of the operand size, so byte lanes can be duplicated
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         size_q <= `BRKB_SEL_OFF;
      end else if (take && cmd_we && cmd_idx == `BRKB_IDX_CYC) begin
         size_q <= cmd_wdata[`BRKB_SZ_HI:`BRKB_SZ_LO];
      end
   end

   // One request outstanding at a time
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= brkb_pkg::BRKB_HS_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         idx_q <= `BRKB_IDX_DATA;
         wdata_q <= `BRKB_RST_WORD;
         cmd_err_q <= 1'b0;
      end else begin
         req_q <= take;
         unique case (state_q)
            brkb_pkg::BRKB_HS_IDLE: if (take) begin
               state_q <= brkb_pkg::BRKB_HS_WAIT;
               we_q <= cmd_we;
               idx_q <= cmd_idx;
               wdata_q <= wdata_d;
               cmd_err_q <= cmd_we && err_d;
            end
            brkb_pkg::BRKB_HS_WAIT: if (rb.ack) begin
               state_q <= brkb_pkg::BRKB_HS_IDLE;
            end
         endcase
      end
   end

   // Completion pulse and captured read data
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cmd_done_q <= 1'b0;
         cmd_rdata_q <= `BRKB_RST_WORD;
      end else begin
         cmd_done_q <= (state_q == brkb_pkg::BRKB_HS_WAIT) && rb.ack;
         if (state_q == brkb_pkg::BRKB_HS_WAIT && rb.ack && !we_q) begin
            cmd_rdata_q <= rb.rdata;
         end
      end
   end

   assign cmd_busy_q = (state_q != brkb_pkg::BRKB_HS_IDLE);
   assign rb.req = req_q;
   assign rb.we = we_q;
   assign rb.idx = idx_q;
   assign rb.wdata = wdata_q;
endmodule // brkb_host

// ===== dv/brkb_chk_sva.sv
// Register port assertions for the channel B break match unit.
// Assumes one clock and an async active-low reset for both ends.
`timescale 1ns/1ns
`include "brkb_defs.svh"
module brkb_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req,
   input wire logic we,
   input wire logic [1:0] idx,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   logic [31:0] data_q;
   logic [31:0] mask_q;
   logic [7:0] cyc_q;
   logic rd_q;
   logic [1:0] rd_idx_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Shadow of written words; reset zero so early reads are judged too
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= `BRKB_RST_WORD;
         mask_q <= `BRKB_RST_WORD;
         cyc_q <= `BRKB_RST_CYC;
      end else if (req && we) begin
         if (idx == `BRKB_IDX_DATA) data_q <= wdata;
         if (idx == `BRKB_IDX_MASK) mask_q <= wdata;
         if (idx == `BRKB_IDX_CYC) cyc_q <= wdata[7:0];
      end
   end
   // Read request noted for the answer cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         rd_idx_q <= `BRKB_IDX_DATA;
      end else begin
         rd_q <= req && !we;
         rd_idx_q <= idx;
      end
   end
   ack_follows_req_a: assert property (req |=> ack)
      else $error("ack missing after request");
   ack_has_cause_a: assert property (ack |-> $past(req))
      else $error("ack without request");
   data_readback_a: assert property (ack && rd_q &&
      rd_idx_q == `BRKB_IDX_DATA |-> rdata == data_q)
      else $error("break data read wrong");
   mask_readback_a: assert property (ack && rd_q &&
      rd_idx_q == `BRKB_IDX_MASK |-> rdata == mask_q)
      else $error("data mask read wrong");
   cyc_readback_a: assert property (ack && rd_q &&
      rd_idx_q == `BRKB_IDX_CYC |-> rdata == {`BRKB_CYC_PAD, cyc_q})
      else $error("cycle select read wrong");
   ctrl_reserved_a: assert property (ack && rd_q &&
      rd_idx_q == `BRKB_IDX_CTRL |-> rdata[31:3] == `BRKB_CTRL_PAD)
      else $error("ctrl reserved bits not zero");
   rdata_hold_a: assert property (!(ack && rd_q) |-> $stable(rdata))
      else $error("read data moved without read");
   byte_lanes_a: assert property (req && we && !idx[1] &&
      cyc_q[1:0] == `BRKB_SZ_BYTE |-> wdata[15:8] == wdata[7:0])
      else $error("byte lanes differ");
   size_needed_a: assert property (req && we &&
      idx == `BRKB_IDX_CTRL && cyc_q[1:0] == `BRKB_SEL_OFF |-> !wdata[2])
      else $error("data include without size");
   cover property (req && we && idx == `BRKB_IDX_CYC);
   cover property (req && we && idx == `BRKB_IDX_CTRL && wdata[2]);
   cover property (ack && rd_q && rd_idx_q == `BRKB_IDX_DATA);
endmodule // brkb_chk

// ===== dv/tb_top.sv
// Bench for both ends of the channel B break match unit.
// Assumes brkb_host drives brkb_dev through brkb_if on one clock.
`timescale 1ns/1ns
`include "brkb_defs.svh"
module tb_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_we = 1'b0;
   logic [1:0] cmd_idx = 2'h0;
   logic [31:0] cmd_wdata = 32'h0000_0000;
   logic cmd_busy_q, cmd_done_q, cmd_err_q;
   logic [31:0] cmd_rdata_q;
   brkb_pkg::brkb_cycle_s local_cycle = '0;
   brkb_pkg::brkb_cycle_s internal_cycle = '0;
   logic local_hit_q, internal_hit_q, local_flag_q, internal_flag_q;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 16;
   logic [33:0] cq[$];
   logic [3:0] hq[$];
   logic [7:0] e_cyc = 8'h00;
   logic [31:0] e_data = 32'h0000_0000;
   logic [31:0] e_mask = 32'h0000_0000;
   logic e_den = 1'b0;
   logic [1:0] e_flag = 2'h0;
   logic [31:0] r = 32'h0000_0000;
   brkb_pkg::brkb_cycle_s sc;
   logic err;
   brkb_if rb();
   brkb_host brkb_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .rb(rb),
      .cmd_valid(cmd_valid), .cmd_we(cmd_we), .cmd_idx(cmd_idx),
      .cmd_wdata(cmd_wdata), .cmd_busy_q(cmd_busy_q),
      .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
      .cmd_rdata_q(cmd_rdata_q));
   brkb_dev brkb_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n), .rb(rb),
      .local_cycle(local_cycle), .internal_cycle(internal_cycle),
      .local_hit_q(local_hit_q), .internal_hit_q(internal_hit_q),
      .local_flag_q(local_flag_q), .internal_flag_q(internal_flag_q));
   brkb_chk brkb_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .req(rb.req),
      .we(rb.we), .idx(rb.idx), .wdata(rb.wdata), .ack(rb.ack),
      .rdata(rb.rdata));
   // Clock and hang guard; the run needs about 2,000 cycles
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One host command; the expected answer goes to the queue first
   task automatic cmd(input logic we, input logic [1:0] idx,
      input logic [31:0] wd, input logic [31:0] exp, input logic er);
      int n;
      n = 0;
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_we <= we;
      cmd_idx <= idx;
      cmd_wdata <= wd;
      cq.push_back({~we, er, exp});
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      while (cmd_done_q !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      // A command that never completes is a hang: count it and stop
      if (cmd_done_q !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
   endtask
   // Reference qualifier and masked compare for one bus cycle
   function automatic logic qual(input brkb_pkg::brkb_cycle_s c);
      logic [31:0] x;
      logic ok;
      x = (c.data ^ e_data) & ~e_mask;
      ok = c.valid;
      if (e_cyc[5:4] == 2'h1) ok = ok & c.fetch;
      if (e_cyc[5:4] == 2'h2) ok = ok & ~c.fetch;
      if (e_cyc[3:2] == 2'h1) ok = ok & ~c.write;
      if (e_cyc[3:2] == 2'h2) ok = ok & c.write;
      if (e_cyc[1:0] != 2'h0) ok = ok & (c.size == e_cyc[1:0]);
      if (e_den) begin
         case (e_cyc[1:0])
            2'h1: ok = ok & (x[7:0] == 8'h00 || x[15:8] == 8'h00);
            2'h2: ok = ok & (x[15:0] == 16'h0000);
            default: ok = ok & (x == 32'h0000_0000);
         endcase
      end
      return ok;
   endfunction
   // Random cycle, mostly close to the programmed data
   function automatic brkb_pkg::brkb_cycle_s rnd_cyc();
      brkb_pkg::brkb_cycle_s c;
      logic [31:0] v;
      v = $random(seed);
      c.valid = v[0] | v[7];
      c.fetch = v[1];
      c.write = v[2];
      c.size = v[4:3];
      c.data = (v[6:5] != 2'h0) ? e_data ^ ($random(seed) & e_mask)
                                : $random(seed);
      return c;
   endfunction
   // One cycle on both buses; hits and flags are due one edge later
   task automatic bus(input brkb_pkg::brkb_cycle_s l,
                      input brkb_pkg::brkb_cycle_s i);
      logic lh, ih;
      lh = (e_cyc[7:6] == 2'h1 || e_cyc[7:6] == 2'h3) && qual(l);
      ih = (e_cyc[7:6] == 2'h2) && qual(i);
      @(posedge clk_sys);
      local_cycle <= l;
      internal_cycle <= i;
      @(posedge clk_sys);
      local_cycle <= '0;
      internal_cycle <= '0;
      e_flag = e_flag | {ih, lh};
      hq.push_back({lh, ih, e_flag[0], e_flag[1]});
   endtask
   // Watcher: compares each result with the oldest note
   always @(negedge clk_sys) begin
      logic [33:0] c;
      logic [3:0] h;
      if (cmd_done_q === 1'b1 && cq.size() > 0) begin
         c = cq.pop_front();
         if (c[33]) check("rdata", cmd_rdata_q, c[31:0]);
         check("err", {31'h0, cmd_err_q}, {31'h0, c[32]});
         check("busy", {31'h0, cmd_busy_q}, 32'h0);
      end
      if (hq.size() > 0) begin
         h = hq.pop_front();
         check("hit", {28'h0, local_hit_q, internal_hit_q, local_flag_q,
            internal_flag_q}, {28'h0, h});
      end else begin
         check("stray", {30'h0, local_hit_q, internal_hit_q}, 32'h0);
      end
   end
   // Reset values first, then random programming and bus traffic
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int k = 0; k < 4; k++) cmd(1'b0, k[1:0], r, 32'h0, 1'b0);
      for (int it = 0; it < 40; it++) begin
         r = $random(seed);
         cmd(1'b1, `BRKB_IDX_CYC, r, 32'h0, 1'b0);
         e_cyc = r[7:0];
         r = $random(seed);
         cmd(1'b1, `BRKB_IDX_DATA, r, 32'h0, 1'b0);
         e_data = (e_cyc[1:0] == `BRKB_SZ_BYTE) ?
            {r[31:16], r[7:0], r[7:0]} : r;
         r = $random(seed) & $random(seed);
         cmd(1'b1, `BRKB_IDX_MASK, r, 32'h0, 1'b0);
         e_mask = (e_cyc[1:0] == `BRKB_SZ_BYTE) ?
            {r[31:16], r[7:0], r[7:0]} : r;
         r = $random(seed);
         err = r[2] && e_cyc[1:0] == `BRKB_SEL_OFF;
         cmd(1'b1, `BRKB_IDX_CTRL, r, 32'h0, err);
         e_den = r[2] && !err;
         e_flag = e_flag & r[1:0];
         cmd(1'b0, `BRKB_IDX_DATA, r, e_data, 1'b0);
         cmd(1'b0, `BRKB_IDX_MASK, r, e_mask, 1'b0);
         cmd(1'b0, `BRKB_IDX_CYC, r, {`BRKB_CYC_PAD, e_cyc}, 1'b0);
         repeat (6) bus(rnd_cyc(), rnd_cyc());
         cmd(1'b0, `BRKB_IDX_CTRL, r, {`BRKB_CTRL_PAD, e_den, e_flag}, 1'b0);
      end
      // A hit in the cycle of a clearing write must keep the flag set
      cmd(1'b1, `BRKB_IDX_CYC, 32'h0000_0040, 32'h0, 1'b0);
      e_cyc = 8'h40;
      cmd(1'b1, `BRKB_IDX_CTRL, 32'h0000_0000, 32'h0, 1'b0);
      e_den = 1'b0;
      e_flag = 2'h0;
      sc = rnd_cyc();
      sc.valid = 1'b1;
      fork
         cmd(1'b1, `BRKB_IDX_CTRL, 32'h0000_0000, 32'h0, 1'b0);
         begin
            @(posedge clk_sys);
            bus(sc, '0);
         end
      join
      cmd(1'b0, `BRKB_IDX_CTRL, r, {30'h0, e_flag}, 1'b0);
      end_of_test();
   end
endmodule // tb_top
